/* phc_pkg.sv */
`default_nettype none
package phc_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned PLAT_W      = 8;
  localparam int unsigned HDR_BYTES   = 48;
  localparam int unsigned DEF_IMG_B   = 2048;
  localparam int unsigned DEF_PAY_B   = 2000;
  localparam int unsigned OFS_VER     = 0;
  localparam int unsigned OFS_REV     = 4;
  localparam int unsigned OFS_DATE    = 8;
  localparam int unsigned OFS_SIG     = 12;
  localparam int unsigned OFS_SUM     = 16;
  localparam int unsigned OFS_LDR     = 20;
  localparam int unsigned OFS_PLAT    = 24;
  localparam int unsigned OFS_DSZ     = 28;
  localparam int unsigned OFS_TSZ     = 32;
  // word indices derived from byte offsets
  localparam logic [29:0] WI_VER      = 30'(OFS_VER / 4);
  localparam logic [29:0] WI_REV      = 30'(OFS_REV / 4);
  localparam logic [29:0] WI_DATE     = 30'(OFS_DATE / 4);
  localparam logic [29:0] WI_SIG      = 30'(OFS_SIG / 4);
  localparam logic [29:0] WI_LDR      = 30'(OFS_LDR / 4);
  localparam logic [29:0] WI_PLAT     = 30'(OFS_PLAT / 4);
  localparam logic [29:0] WI_DSZ      = 30'(OFS_DSZ / 4);
  localparam logic [29:0] WI_TSZ      = 30'(OFS_TSZ / 4);
  localparam logic [29:0] WI_HDR_LAST = 30'(HDR_BYTES / 4 - 1);
  localparam logic [29:0] HDR_WORDS   = 30'(HDR_BYTES / 4);
  localparam logic [29:0] DEF_IMG_W   = 30'(DEF_IMG_B / 4);
  localparam logic [29:0] DEF_PAY_W   = 30'(DEF_PAY_B / 4);
  localparam logic [32:0] HDR_B33     = 33'(HDR_BYTES);
  // checker states, gray along the usual path
  typedef enum logic [1:0] {
    ST_HDR = 2'b00,
    ST_PAY = 2'b01,
    ST_EXT = 2'b11,
    ST_RES = 2'b10
  } phc_state_e;
endpackage
`default_nettype wire

/* phc_checker.sv */
`timescale 1ns/100ps
`default_nettype none

// word fifo between the loader and the checker
module phc_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      wp_nxt;
  logic [AW:0]      rp_r;
  logic [AW:0]      rp_nxt;
  logic             push;
  logic             pop;

  // honest full and empty from pointers with wrap bit
  always_comb begin
    in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
    out_valid = (wp_r != rp_r);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_nxt    = push ? wp_r + 1'b1 : wp_r;
    rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
    out_data  = mem[rp_r[AW-1:0]];
  end

  // pointer registers and storage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// image header checker top
module phc_checker #(
  parameter int unsigned DEPTH = phc_pkg::FIFO_DEPTH
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        img_valid,
  output logic                             img_ready,
  input  wire logic [31:0]                 img_data,
  input  wire logic                        chk_hold,
  input  wire logic [31:0]                 proc_signature,
  input  wire logic [phc_pkg::PLAT_W-1:0]  platform_id,
  output logic                             res_valid,
  output logic                             res_pass,
  output logic                             err_sig,
  output logic                             err_sum,
  output logic                             err_size,
  output logic                             err_plat,
  output logic      [31:0]                 hdr_version,
  output logic signed [31:0]               upd_revision,
  output logic      [7:0]                  date_month,
  output logic      [7:0]                  date_day,
  output logic      [15:0]                 date_year,
  output logic      [31:0]                 loader_req,
  output logic      [31:0]                 ext_offset,
  output logic      [31:0]                 ext_len
);
  logic                  f_valid;
  logic                  f_ready;
  logic [31:0]           f_data;
  logic                  pop;
  phc_pkg::phc_state_e   st_r;
  phc_pkg::phc_state_e   st_nxt;
  logic [29:0]           idx_r;
  logic [29:0]           idx_nxt;
  logic [31:0]           sum_r;
  logic [31:0]           sum_nxt;
  logic [31:0]           sig_r;
  logic [31:0]           sig_nxt;
  logic [31:0]           pflg_r;
  logic [31:0]           pflg_nxt;
  logic [31:0]           dsz_r;
  logic [31:0]           dsz_nxt;
  logic [31:0]           tsz_r;
  logic [31:0]           tsz_nxt;
  logic [31:0]           ver_nxt;
  logic [31:0]           rev_nxt;
  logic [31:0]           date_nxt;
  logic [31:0]           ldr_nxt;
  logic [29:0]           end_pay;
  logic [29:0]           end_all;
  logic                  bad_size;
  logic                  rv_nxt;
  logic                  pass_nxt;
  logic                  esig_nxt;
  logic                  esum_nxt;
  logic                  esize_r;
  logic                  esize_nxt;
  logic                  eplat_nxt;
  logic [31:0]           eoff_nxt;
  logic [31:0]           elen_nxt;

  phc_fifo #(
    .WIDTH (phc_pkg::WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (img_valid),
    .in_ready  (img_ready),
    .in_data   (img_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // image length from the size fields
  always_comb begin
    if (dsz_r == '0) begin
      end_pay = phc_pkg::HDR_WORDS + phc_pkg::DEF_PAY_W;
      end_all = phc_pkg::DEF_IMG_W;
    end else begin
      end_pay = phc_pkg::HDR_WORDS + dsz_r[31:2];
      end_all = tsz_r[31:2];
    end
    bad_size = (dsz_r != '0) && ((dsz_r[1:0] != 2'b00) || (tsz_r[1:0] != 2'b00) ||
               ({1'b0, tsz_r} < ({1'b0, dsz_r} + phc_pkg::HDR_B33)));
  end

  // word walk, field capture, sum and verdict
  always_comb begin
    f_ready   = !chk_hold && (st_r != phc_pkg::ST_RES);
    pop       = f_valid && f_ready;
    st_nxt    = st_r;
    idx_nxt   = idx_r;
    sum_nxt   = sum_r;
    sig_nxt   = sig_r;
    pflg_nxt  = pflg_r;
    dsz_nxt   = dsz_r;
    tsz_nxt   = tsz_r;
    ver_nxt   = hdr_version;
    rev_nxt   = upd_revision;
    date_nxt  = {date_month, date_day, date_year};
    ldr_nxt   = loader_req;
    rv_nxt    = 1'b0;
    pass_nxt  = res_pass;
    esig_nxt  = err_sig;
    esum_nxt  = err_sum;
    esize_nxt = esize_r;
    eplat_nxt = err_plat;
    eoff_nxt  = ext_offset;
    elen_nxt  = ext_len;
    case (st_r)
      phc_pkg::ST_HDR: begin
        if (pop) begin
          idx_nxt = idx_r + 30'h1;
          sum_nxt = sum_r + f_data;
          if (idx_r == phc_pkg::WI_VER) ver_nxt = f_data;
          if (idx_r == phc_pkg::WI_REV) rev_nxt = f_data;
          if (idx_r == phc_pkg::WI_DATE) date_nxt = f_data;
          if (idx_r == phc_pkg::WI_SIG) sig_nxt = f_data;
          if (idx_r == phc_pkg::WI_LDR) ldr_nxt = f_data;
          if (idx_r == phc_pkg::WI_PLAT) pflg_nxt = f_data;
          if (idx_r == phc_pkg::WI_DSZ) dsz_nxt = f_data;
          if (idx_r == phc_pkg::WI_TSZ) tsz_nxt = f_data;
          if (idx_r == phc_pkg::WI_HDR_LAST) begin
            st_nxt = bad_size ? phc_pkg::ST_RES : phc_pkg::ST_PAY;
          end
        end
      end
      phc_pkg::ST_PAY: begin
        if (pop) begin
          idx_nxt = idx_r + 30'h1;
          sum_nxt = sum_r + f_data;
          if (idx_r == end_pay - 30'h1) begin
            st_nxt = (end_all == end_pay) ? phc_pkg::ST_RES : phc_pkg::ST_EXT;
          end
        end
      end
      phc_pkg::ST_EXT: begin
        if (pop) begin
          idx_nxt = idx_r + 30'h1;
          if (idx_r == end_all - 30'h1) st_nxt = phc_pkg::ST_RES;
        end
      end
      default: begin
        rv_nxt    = 1'b1;
        esig_nxt  = (sig_r != proc_signature);
        esum_nxt  = (sum_r != '0);
        esize_nxt = bad_size;
        eplat_nxt = ((pflg_r[phc_pkg::PLAT_W-1:0] & platform_id) == '0);
        pass_nxt  = !(esig_nxt || esum_nxt || esize_nxt || eplat_nxt);
        eoff_nxt  = (dsz_r == '0) ? 32'(phc_pkg::DEF_IMG_B) : dsz_r + 32'(phc_pkg::HDR_BYTES);
        elen_nxt  = (dsz_r == '0 || bad_size) ? 32'h0 :
                    tsz_r - (dsz_r + 32'(phc_pkg::HDR_BYTES));
        st_nxt    = phc_pkg::ST_HDR;
        idx_nxt   = '0;
        sum_nxt   = '0;
        dsz_nxt   = '0;
        tsz_nxt   = '0;
      end
    endcase
  end

  // state and result registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r         <= phc_pkg::ST_HDR;
      idx_r        <= '0;
      sum_r        <= '0;
      sig_r        <= '0;
      pflg_r       <= '0;
      dsz_r        <= '0;
      tsz_r        <= '0;
      hdr_version  <= '0;
      upd_revision <= '0;
      {date_month, date_day, date_year} <= '0;
      loader_req   <= '0;
      res_valid    <= 1'b0;
      res_pass     <= 1'b0;
      err_sig      <= 1'b0;
      err_sum      <= 1'b0;
      esize_r      <= 1'b0;
      err_plat     <= 1'b0;
      ext_offset   <= '0;
      ext_len      <= '0;
    end else begin
      st_r         <= st_nxt;
      idx_r        <= idx_nxt;
      sum_r        <= sum_nxt;
      sig_r        <= sig_nxt;
      pflg_r       <= pflg_nxt;
      dsz_r        <= dsz_nxt;
      tsz_r        <= tsz_nxt;
      hdr_version  <= ver_nxt;
      upd_revision <= rev_nxt;
      {date_month, date_day, date_year} <= date_nxt;
      loader_req   <= ldr_nxt;
      res_valid    <= rv_nxt;
      res_pass     <= pass_nxt;
      err_sig      <= esig_nxt;
      err_sum      <= esum_nxt;
      esize_r      <= esize_nxt;
      err_plat     <= eplat_nxt;
      ext_offset   <= eoff_nxt;
      ext_len      <= elen_nxt;
    end
  end

  assign err_size = esize_r;

  // checks on the verdict and field capture
  sig_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == phc_pkg::ST_RES |=> res_valid && (err_sig == ($past(sig_r) != $past(proc_signature))))
    else $error("signature flag wrong");
  sig_refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    res_valid && err_sig |-> !res_pass)
    else $error("mismatched signature passed");
  sum_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == phc_pkg::ST_RES |=> err_sum == ($past(sum_r) != 32'h0))
    else $error("checksum flag wrong");
  hdr_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == phc_pkg::ST_HDR && pop && idx_r == phc_pkg::WI_HDR_LAST |=> st_r != phc_pkg::ST_HDR)
    else $error("header not closed after 48 bytes");
  def_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == phc_pkg::ST_PAY && dsz_r == 32'h0 && pop && idx_r == phc_pkg::DEF_IMG_W - 30'h1
    |=> st_r == phc_pkg::ST_RES)
    else $error("default length wrong");
  tot_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r == phc_pkg::ST_PAY || st_r == phc_pkg::ST_EXT) && dsz_r != 32'h0 |-> idx_r < tsz_r[31:2])
    else $error("walk beyond total size");
  ext_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == phc_pkg::ST_RES && dsz_r != 32'h0 && !bad_size
    |=> ext_len == $past(tsz_r) - $past(dsz_r) - 32'(phc_pkg::HDR_BYTES))
    else $error("extension length wrong");
  rev_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == phc_pkg::ST_HDR && pop && idx_r == phc_pkg::WI_REV |=> upd_revision == $signed($past(f_data)))
    else $error("revision not captured");
  date_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == phc_pkg::ST_HDR && pop && idx_r == phc_pkg::WI_DATE |=> date_month == $past(f_data[31:24])
    && date_year == $past(f_data[15:0]))
    else $error("date not captured");
  plat_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r == phc_pkg::ST_RES |=> err_plat == (($past(pflg_r[7:0]) & $past(platform_id)) == 8'h0))
    else $error("platform flag wrong");
  pass_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    res_valid |-> res_pass == !(err_sig || err_sum || err_size || err_plat))
    else $error("pass disagrees with flags");
  one_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    res_valid |=> !res_valid)
    else $error("result pulse too long");

  // main scenarios
  pass_cov: cover property (@(posedge ref_clk) disable iff (!rst_n) res_valid && res_pass);
  ext_cov: cover property (@(posedge ref_clk) disable iff (!rst_n) st_r == phc_pkg::ST_EXT && pop);
  sig_cov: cover property (@(posedge ref_clk) disable iff (!rst_n) res_valid && err_sig);
  size_cov: cover property (@(posedge ref_clk) disable iff (!rst_n) res_valid && err_size);
endmodule

`default_nettype wire

/* phc_loader_model.sv */
`timescale 1ns/100ps
`default_nettype none

// behavioural loader feeding image words, promptly or with a gap after each word
module phc_loader_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [9:0]  n_words,
  input  wire logic        slow,
  output logic             img_valid,
  input  wire logic        img_ready,
  output logic      [31:0] img_data,
  output logic             busy
);
  logic [31:0] mem [0:511];
  logic [9:0]  idx;
  logic        gap;

  // image held as header, payload, extension in ascending word order from zero
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      img_valid <= 1'b0;
      img_data  <= 32'h5a5a5a5a;
      busy      <= 1'b0;
      idx       <= 10'h000;
      gap       <= 1'b0;
    end else if (start && !busy) begin
      busy      <= 1'b1;
      idx       <= 10'h000;
      img_valid <= 1'b1;
      img_data  <= mem[0];
    end else if (busy && img_valid && img_ready) begin
      if (idx + 10'h001 == n_words) begin
        busy      <= 1'b0;
        img_valid <= 1'b0;
        img_data  <= ~img_data;  // released bus shows no stale word
      end else if (slow) begin
        img_valid <= 1'b0;
        img_data  <= ~img_data;
        idx       <= idx + 10'h001;
        gap       <= 1'b1;
      end else begin
        idx       <= idx + 10'h001;
        img_data  <= mem[idx + 10'h001];
      end
    end else if (gap) begin
      gap       <= 1'b0;
      img_valid <= 1'b1;
      img_data  <= mem[idx];
    end
  end
endmodule

`default_nettype wire

/* patch_image_header_checker_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module patch_image_header_checker_bench;
  logic               ref_clk        = 1'b0;
  logic               rst_n          = 1'b0;
  logic               start          = 1'b0;
  logic               slow           = 1'b0;
  logic               chk_hold       = 1'b0;
  logic [9:0]         n_words        = 10'h000;
  logic [31:0]        proc_signature = 32'h0000a5c3;  // arbitrary identity value
  logic [7:0]         platform_id    = 8'h04;
  logic               img_valid, img_ready, res_valid, res_pass, busy;
  logic               err_sig, err_sum, err_size, err_plat;
  logic [31:0]        img_data, hdr_version, loader_req, ext_offset, ext_len;
  logic signed [31:0] upd_revision;
  logic [7:0]         date_month, date_day;
  logic [15:0]        date_year;
  int                 miscompares     = 0;
  int                 samples_checked = 0;

  // free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  phc_checker DUT (.ref_clk, .rst_n, .img_valid, .img_ready, .img_data, .chk_hold, .proc_signature,
    .platform_id, .res_valid, .res_pass, .err_sig, .err_sum, .err_size, .err_plat, .hdr_version,
    .upd_revision, .date_month, .date_day, .date_year, .loader_req, .ext_offset, .ext_len);

  phc_loader_model lm (.ref_clk, .rst_n, .start, .n_words, .slow, .img_valid, .img_ready, .img_data, .busy);

  // compare one value, report and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare result flags packed as pass, sig, sum, size, plat
  task automatic chk_res(input logic [4:0] exp);
    chk({27'h0, res_pass, err_sig, err_sum, err_size, err_plat}, {27'h0, exp});
  endtask

  // fill the loader with an image whose header and payload sum to zero
  task automatic build(input logic [31:0] dsz, input logic [31:0] tsz, input logic [31:0] flags,
                       input int nw, input logic [31:0] sigx);
    int          npay;
    logic [31:0] s;
    npay = (dsz == 32'h0) ? 500 : int'(dsz) / 4;
    s = 32'h0;
    for (int i = 0; i < nw; i++) lm.mem[i] = 32'h3c000000 + 32'(i * 7);
    lm.mem[0] = 32'h00000001;
    lm.mem[1] = 32'hfffffff6;
    lm.mem[2] = 32'h07181998;
    lm.mem[3] = proc_signature ^ sigx;
    lm.mem[4] = 32'h0;
    lm.mem[5] = 32'h00000001;
    lm.mem[6] = flags;
    lm.mem[7] = dsz;
    lm.mem[8] = tsz;
    for (int i = 0; i < nw && i < 12 + npay; i++) s += lm.mem[i];
    lm.mem[4] = -s;
    n_words <= 10'(nw);
  endtask

  // send the image, optionally letting the fifo fill first, then wait for the result
  task automatic run(input logic slw, input logic hold);
    int n;
    n = 0;
    @(posedge ref_clk);
    slow     <= slw;
    chk_hold <= hold;
    start    <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    if (hold) begin
      repeat (30) @(posedge ref_clk);
      #1;
      chk({31'h0, img_ready}, 32'h0);
      @(posedge ref_clk);
      chk_hold <= 1'b0;
    end
    while (res_valid !== 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 4000) miscompares++;
    chk({31'h0, busy}, 32'h0);
  endtask

  // good image with extension table, fifo filled to refusal first
  task automatic t_good();
    build(32'h8, 32'h50, 32'hffffff24, 20, 32'h0);
    run(1'b0, 1'b1);
    chk_res(5'b10000);
    chk(hdr_version, 32'h00000001);
    chk(upd_revision, 32'hfffffff6);
    chk({date_month, date_day, date_year}, 32'h07181998);
    chk(loader_req, 32'h00000001);
    chk(ext_offset, 32'h38);
    chk(ext_len, 32'h18);
    $display("test good image done");
  endtask

  // single-bit signature difference with a slow loader
  task automatic t_sig();
    build(32'h8, 32'h50, 32'hffffff24, 20, 32'h00000100);
    run(1'b1, 1'b0);
    chk_res(5'b01000);
    $display("test signature done");
  endtask

  // corrupted payload word breaks the sum
  task automatic t_sum();
    build(32'h8, 32'h50, 32'hffffff24, 20, 32'h0);
    lm.mem[13] = lm.mem[13] ^ 32'h00000100;
    run(1'b0, 1'b0);
    chk_res(5'b00100);
    $display("test checksum done");
  endtask

  // platform bits disjoint from the mask, upper flag bits set
  task automatic t_plat();
    @(posedge ref_clk);
    platform_id <= 8'h02;
    build(32'h8, 32'h50, 32'hffffff24, 20, 32'h0);
    run(1'b0, 1'b0);
    chk_res(5'b00001);
    @(posedge ref_clk);
    platform_id <= 8'h04;
    $display("test platform done");
  endtask

  // zero payload size means a fixed 512-word image
  task automatic t_default();
    build(32'h0, 32'h0, 32'h00000004, 512, 32'h0);
    run(1'b0, 1'b0);
    chk_res(5'b10000);
    chk(ext_offset, 32'h800);
    chk(ext_len, 32'h0);
    $display("test default size done");
  endtask

  // total smaller than header plus payload, then resync by reset
  task automatic t_size();
    build(32'h8, 32'h28, 32'hffffff24, 12, 32'h0);
    run(1'b0, 1'b0);
    chk_res(5'b00010);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    $display("test size error done");
  endtask

  // print counts and verdict, end the run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog sized well above the expected run of under a thousand cycles
  initial begin
    #300000;
    miscompares++;
    wrap_up();
  end

  // reset then scenarios
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_good();
    t_sig();
    t_sum();
    t_plat();
    t_default();
    t_size();
    t_good();
    wrap_up();
  end
endmodule

`default_nettype wire
